/* uod_pkg.sv */
// Shared constants and carrier types for the user OTP and phase diagnostic register block.
// Assumes a single 250 MHz system clock; serial link pins are sampled, not used as clocks.
package uod_pkg;

	localparam int ADDR_W      = 7;
	localparam int DATA_W      = 16;
	localparam int CH_COUNT    = 3;
	localparam int FRAME_BITS  = 24;
	localparam int HEADER_BITS = 8;
	localparam int CNT_W       = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_DIAG    = 7'h33;
	localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 7'h36;
	localparam logic [ADDR_W-1:0] ADDR_OTP     = 7'h48;

	// Reset values
	localparam logic [DATA_W-1:0] RST_DIAG    = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SCRATCH = 16'h0000;
	localparam logic [DATA_W-1:0] RST_OTP     = 16'h0000;

	// Field positions: channel n high-side enable at DIAG_HS_MSB - 2n, low-side one below
	localparam int DIAG_HS_MSB     = 5;
	localparam int DIAG_FIELD_W    = 6;
	localparam int OTP_VERIFY_BIT  = 4;
	localparam int OTP_UNLOCK_MSB  = 3;
	localparam int OTP_UNLOCK_LSB  = 1;
	localparam int OTP_PROGRAM_BIT = 0;
	localparam int OTP_USED_W      = 5;

	// Unlock codes and read-back values
	localparam logic [2:0] UNLOCK_FIRST  = 3'h2;
	localparam logic [2:0] UNLOCK_SECOND = 3'h1;
	localparam logic [2:0] UNLOCK_THIRD  = 3'h4;
	localparam logic [2:0] UNLOCK_OPEN   = 3'h7;
	localparam logic [2:0] UNLOCK_IDLE   = 3'h0;

	// Frame header: bit 7 high means read, bits 6..0 address
	localparam int READ_FLAG_BIT = 7;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} uod_wr_t;

	typedef struct packed {
		logic [CH_COUNT-1:0] hs;
		logic [CH_COUNT-1:0] ls;
	} uod_vds_t;

endpackage

/* uod_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherency is offered across bits.
`timescale 1ns/1ps
module uod_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta;

	if (WIDTH < 1)
	begin : g_chk
		$error("uod_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta <= '0;
			o_q  <= '0;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule

/* uod_unlock.sv */
// Three-step unlock tracker guarding the OTP program bit.
// Assumes i_wr is a one-cycle pulse per write to the OTP control register.
`timescale 1ns/1ps
module uod_unlock
	import uod_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_wr,
	input  wire logic [2:0] i_code,
	output logic            o_open,
	output logic      [2:0] o_field
);

	typedef enum logic [1:0] {ST_IDLE, ST_GOT1, ST_GOT2, ST_OPEN} uod_unlock_st_t;

	uod_unlock_st_t state;
	uod_unlock_st_t next_state;

	always_comb
	begin
		next_state = state;
		if (i_wr)
		begin
			case (state)
				ST_IDLE: next_state = (i_code == UNLOCK_FIRST)  ? ST_GOT1 : ST_IDLE;
				ST_GOT1: next_state = (i_code == UNLOCK_SECOND) ? ST_GOT2 : ST_IDLE;
				ST_GOT2: next_state = (i_code == UNLOCK_THIRD)  ? ST_OPEN : ST_IDLE;
				ST_OPEN: next_state = ST_IDLE;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Intermediate steps read back as the idle value so the code is not leaked
	assign o_open  = (state == ST_OPEN);
	assign o_field = o_open ? UNLOCK_OPEN : UNLOCK_IDLE;

endmodule

/* uod_top.sv */
// User OTP control, serial scratch register and phase diagnostic switch enables,
// reached over the device's four-wire serial register port.
// Assumes SCLK, SDI and SCS_N come from the host's clock domain; the OTP macro and
// the drain-source fault logic run on I_CLK_SYS.
// Function
// - High-side enable: switch on, all flags live
// - Low-side enable: that low-side flag live
// - All enables zero clears drain-source flags
// - Scratch register stores, reads back, does nothing
// - Unlock needs codes 2, 1, 4 in order
// - Wrong code ignored, tracker returns to idle
// - Field reads 7 unlocked, 0 when idle
// - Any OTP control register write after unlock relocks tracker
// - Program bit write blocked unless unlocked
// - Program bit starts programming, self-clears when done
`timescale 1ns/1ps
module uod_top
	import uod_pkg::*;
(
	input  wire logic                I_CLK_SYS,
	input  wire logic                I_RST,
	input  wire logic                I_SCS_N,
	input  wire logic                I_SCLK,
	input  wire logic                I_SDI,
	output logic                     O_SDO,
	output logic                     O_SDO_OE,
	input  wire logic [CH_COUNT-1:0] I_VDS_HS_CMP,
	input  wire logic [CH_COUNT-1:0] I_VDS_LS_CMP,
	input  wire logic [CH_COUNT-1:0] I_VDS_HS_FAULT,
	input  wire logic [CH_COUNT-1:0] I_VDS_LS_FAULT,
	output logic      [CH_COUNT-1:0] O_DIAG_SWITCH_HS,
	output logic      [CH_COUNT-1:0] O_DIAG_SWITCH_LS,
	output logic      [CH_COUNT-1:0] O_HS_DRAIN_SOURCE_FLAG,
	output logic      [CH_COUNT-1:0] O_LS_DRAIN_SOURCE_FLAG,
	output logic                     O_OTP_PROGRAM_REQ,
	output logic                     O_OTP_VERIFY_REQ,
	input  wire logic                I_OTP_DONE,
	input  wire logic                I_OTP_CRC_BAD,
	output logic                     O_OTP_CRC_FAIL_FLAG
);

	// Synchronised link pins and comparator levels
	logic                      s_cs_n;
	logic                      s_sclk;
	logic                      s_sdi;
	logic                      sclk_d;
	uod_vds_t                  s_cmp;

	// Frame shifter
	logic [CNT_W-1:0]          bit_cnt;
	logic [FRAME_BITS-2:0]     rx;
	logic [DATA_W-1:0]         tx;
	logic                      hdr_read;

	// Registers
	logic [DIAG_FIELD_W-1:0]   diag_en;
	logic [DATA_W-1:0]         scratch;
	logic                      verify_go;
	logic                      program_go;
	logic                      crc_fail;
	uod_vds_t                  flag;

	// Decode wires
	logic                      sclk_rise;
	logic                      sclk_fall;
	logic                      hdr_done;
	logic                      frame_done;
	logic [ADDR_W-1:0]         peek_addr;
	logic [DATA_W-1:0]         rd_data;
	uod_wr_t                   wr;
	logic                      wr_stb;
	logic                      wr_diag;
	logic                      wr_scratch;
	logic                      wr_otp;
	logic                      unlock_open;
	logic [2:0]                unlock_field;
	logic                      otp_busy;
	logic                      start_program;
	logic                      start_verify;
	logic                      otp_finish;
	logic                      clear_flags;
	logic [CH_COUNT-1:0]       en_hs;
	logic [CH_COUNT-1:0]       en_ls;
	logic                      mon_hs;
	uod_vds_t                  fault_in;

	// Frame counter must reach the full frame length without wrapping
	if (FRAME_BITS >= (1 << CNT_W))
	begin : g_chk
		$error("uod_top: CNT_W too narrow for FRAME_BITS");
	end

	uod_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.i_clk (I_CLK_SYS),
		.i_rst (I_RST),
		.i_d   ({I_SCS_N, I_SCLK, I_SDI}),
		.o_q   ({s_cs_n, s_sclk, s_sdi})
	);

	// Comparators are analog and free-running, so they cross like pins
	uod_sync #(
		.WIDTH (2*CH_COUNT)
	) u_cmp_sync (
		.i_clk (I_CLK_SYS),
		.i_rst (I_RST),
		.i_d   ({I_VDS_HS_CMP, I_VDS_LS_CMP}),
		.o_q   (s_cmp)
	);

	// Link edge detection on the second synchroniser stage only
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			sclk_d <= 1'b0;
		else
			sclk_d <= s_sclk;
	end

	assign sclk_rise  = s_sclk & ~sclk_d & ~s_cs_n;
	assign sclk_fall  = ~s_sclk & sclk_d & ~s_cs_n;
	assign hdr_done   = sclk_rise && (bit_cnt == CNT_W'(HEADER_BITS - 1));
	assign frame_done = sclk_rise && (bit_cnt == CNT_W'(FRAME_BITS - 1));
	assign peek_addr  = {rx[ADDR_W-2:0], s_sdi};

	// Bits beyond the 24th are dropped; a short frame writes nothing
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			bit_cnt  <= '0;
			rx       <= '0;
			hdr_read <= 1'b0;
		end
		else if (s_cs_n)
		begin
			bit_cnt  <= '0;
			hdr_read <= 1'b0;
		end
		else if (sclk_rise && (bit_cnt != CNT_W'(FRAME_BITS)))
		begin
			rx      <= {rx[FRAME_BITS-3:0], s_sdi};
			bit_cnt <= bit_cnt + CNT_W'(1);
			if (hdr_done)
				hdr_read <= rx[ADDR_W-1];
		end
	end

	// Read data loaded at header end, shifted out on falling edges
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			tx    <= '0;
			O_SDO <= 1'b0;
		end
		else if (s_cs_n)
		begin
			O_SDO <= 1'b0;
		end
		else if (hdr_done)
		begin
			tx <= rd_data;
		end
		else if (sclk_fall && (bit_cnt >= CNT_W'(HEADER_BITS)))
		begin
			O_SDO <= tx[DATA_W-1];
			tx    <= {tx[DATA_W-2:0], 1'b0};
		end
	end

	assign O_SDO_OE = ~s_cs_n & hdr_read;

	always_comb
	begin
		case (peek_addr)
			ADDR_DIAG:    rd_data = {{(DATA_W-DIAG_FIELD_W){1'b0}}, diag_en};
			ADDR_SCRATCH: rd_data = scratch;
			ADDR_OTP:     rd_data = {{(DATA_W-OTP_USED_W){1'b0}}, verify_go, unlock_field,
				1'b0};
			default:      rd_data = '0;
		endcase
	end

	// Write commit at the 24th rising edge of a write frame
	assign wr.addr    = rx[FRAME_BITS-3:DATA_W-1];
	assign wr.data    = {rx[DATA_W-2:0], s_sdi};
	assign wr_stb     = frame_done & ~rx[FRAME_BITS-2];
	assign wr_diag    = wr_stb && (wr.addr == ADDR_DIAG);
	assign wr_scratch = wr_stb && (wr.addr == ADDR_SCRATCH);
	assign wr_otp     = wr_stb && (wr.addr == ADDR_OTP);

	uod_unlock u_unlock (
		.i_clk   (I_CLK_SYS),
		.i_rst   (I_RST),
		.i_wr    (wr_otp),
		.i_code  (wr.data[OTP_UNLOCK_MSB:OTP_UNLOCK_LSB]),
		.o_open  (unlock_open),
		.o_field (unlock_field)
	);

	// Program wins if a host writes both bits at once
	assign otp_busy      = program_go | verify_go;
	assign start_program = wr_otp & wr.data[OTP_PROGRAM_BIT] & unlock_open & ~otp_busy;
	assign start_verify  = wr_otp & wr.data[OTP_VERIFY_BIT] & ~otp_busy
		& ~wr.data[OTP_PROGRAM_BIT];
	assign otp_finish    = I_OTP_DONE & otp_busy;

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			diag_en <= RST_DIAG[DIAG_FIELD_W-1:0];
			scratch <= RST_SCRATCH;
		end
		else
		begin
			if (wr_diag)
				diag_en <= wr.data[DIAG_FIELD_W-1:0];
			if (wr_scratch)
				scratch <= wr.data;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			program_go <= RST_OTP[OTP_PROGRAM_BIT];
			verify_go  <= RST_OTP[OTP_VERIFY_BIT];
			crc_fail   <= 1'b0;
		end
		else if (otp_finish)
		begin
			program_go <= 1'b0;
			verify_go  <= 1'b0;
			if (verify_go)
				crc_fail <= I_OTP_CRC_BAD;
		end
		else if (start_program)
		begin
			program_go <= 1'b1;
		end
		else if (start_verify)
		begin
			verify_go <= 1'b1;
			crc_fail  <= 1'b0;
		end
	end

	// Driver-block quiet state before programming is the host's duty, not checked here
	assign O_OTP_PROGRAM_REQ   = program_go;
	assign O_OTP_VERIFY_REQ    = verify_go;
	assign O_OTP_CRC_FAIL_FLAG = crc_fail;

	// Phase diagnostic enables and drain-source flag selection
	assign clear_flags = wr_diag && (wr.data[DIAG_FIELD_W-1:0] == '0);
	assign fault_in    = {I_VDS_HS_FAULT, I_VDS_LS_FAULT};
	assign mon_hs      = |en_hs;

	for (genvar ch = 0; ch < CH_COUNT; ch++)
	begin : g_ch
		assign en_hs[ch] = diag_en[DIAG_HS_MSB - 2*ch];
		assign en_ls[ch] = diag_en[DIAG_HS_MSB - 2*ch - 1];

		// A fault arriving with the clear survives it
		// Clear outranks live mode: the old enables still stand in the clearing cycle
		always_ff @(posedge I_CLK_SYS or posedge I_RST)
		begin
			if (I_RST)
			begin
				flag.hs[ch] <= 1'b0;
				flag.ls[ch] <= 1'b0;
			end
			else
			begin
				if (clear_flags)
					flag.hs[ch] <= fault_in.hs[ch];
				else if (mon_hs)
					flag.hs[ch] <= s_cmp.hs[ch];
				else
					flag.hs[ch] <= flag.hs[ch] | fault_in.hs[ch];

				if (clear_flags)
					flag.ls[ch] <= fault_in.ls[ch];
				else if (mon_hs || en_ls[ch])
					flag.ls[ch] <= s_cmp.ls[ch];
				else
					flag.ls[ch] <= flag.ls[ch] | fault_in.ls[ch];
			end
		end
	end

	assign O_DIAG_SWITCH_HS       = en_hs;
	assign O_DIAG_SWITCH_LS       = en_ls;
	assign O_HS_DRAIN_SOURCE_FLAG = flag.hs;
	assign O_LS_DRAIN_SOURCE_FLAG = flag.ls;

endmodule

/* uod_top_sva.sv */
// Concurrent checks on the ports of uod_top.
// Assumes one clock domain and that the OTP macro pulses I_OTP_DONE only while busy.
`timescale 1ns/1ps
module uod_top_sva
	import uod_pkg::*;
(
	input wire logic                I_CLK_SYS,
	input wire logic                I_RST,
	input wire logic                I_SCS_N,
	input wire logic [CH_COUNT-1:0] I_VDS_HS_CMP,
	input wire logic [CH_COUNT-1:0] I_VDS_LS_CMP,
	input wire logic [CH_COUNT-1:0] I_VDS_HS_FAULT,
	input wire logic [CH_COUNT-1:0] I_VDS_LS_FAULT,
	input wire logic [CH_COUNT-1:0] O_DIAG_SWITCH_HS,
	input wire logic [CH_COUNT-1:0] O_DIAG_SWITCH_LS,
	input wire logic [CH_COUNT-1:0] O_HS_DRAIN_SOURCE_FLAG,
	input wire logic [CH_COUNT-1:0] O_LS_DRAIN_SOURCE_FLAG,
	input wire logic                O_OTP_PROGRAM_REQ,
	input wire logic                O_OTP_VERIFY_REQ,
	input wire logic                I_OTP_DONE,
	input wire logic                I_OTP_CRC_BAD,
	input wire logic                O_OTP_CRC_FAIL_FLAG
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	AST_PRG_DONE: assert property (O_OTP_PROGRAM_REQ && I_OTP_DONE |=> !O_OTP_PROGRAM_REQ)
		else $error("program request outlived done");
	AST_VER_DONE: assert property (O_OTP_VERIFY_REQ && I_OTP_DONE |=>
		!O_OTP_VERIFY_REQ && O_OTP_CRC_FAIL_FLAG == $past(I_OTP_CRC_BAD))
		else $error("verify end or crc flag wrong");
	AST_VER_CLR: assert property ($rose(O_OTP_VERIFY_REQ) |-> ##[0:1] !O_OTP_CRC_FAIL_FLAG)
		else $error("crc flag not cleared at verify start");
	AST_NO_BOTH: assert property (!(O_OTP_PROGRAM_REQ && O_OTP_VERIFY_REQ))
		else $error("program and verify both active");
	AST_PRG_CS: assert property ($rose(O_OTP_PROGRAM_REQ) |-> $past(!I_SCS_N, 2))
		else $error("program started outside a frame");
	AST_SW_CS: assert property (!$stable(O_DIAG_SWITCH_HS) |-> $past(!I_SCS_N, 2))
		else $error("diag switch moved outside a frame");
	AST_LIVE_HS: assert property ((|O_DIAG_SWITCH_HS && $stable(I_VDS_HS_CMP))[*5]
		|-> O_HS_DRAIN_SOURCE_FLAG == I_VDS_HS_CMP)
		else $error("hs flag not live");
	AST_LIVE_LS: assert property ((O_DIAG_SWITCH_LS[1] && $stable(I_VDS_LS_CMP))[*5]
		|-> O_LS_DRAIN_SOURCE_FLAG[1] == I_VDS_LS_CMP[1])
		else $error("ls flag not live");
	AST_CLR: assert property ($fell(|{O_DIAG_SWITCH_HS, O_DIAG_SWITCH_LS})
		&& !(|{I_VDS_HS_FAULT, I_VDS_LS_FAULT})
		|-> ##[0:2] {O_HS_DRAIN_SOURCE_FLAG, O_LS_DRAIN_SOURCE_FLAG} == 6'h00)
		else $error("flags not cleared");
	COV_PRG: cover property ($rose(O_OTP_PROGRAM_REQ));
	COV_FAIL: cover property (O_OTP_VERIFY_REQ && I_OTP_DONE && I_OTP_CRC_BAD);
	COV_LIVE: cover property ($rose(|O_DIAG_SWITCH_HS));
endmodule
bind uod_top uod_top_sva sva (.*);

/* uod_host.sv */
// Serial register host: 24-bit frames, SCLK idle low, 160 ns bit time.
// Assumes calls start on a system clock falling edge so pin moves stay off sampling edges.
`timescale 1ns/1ps
module uod_host
(
	input  wire logic i_sdo,
	output logic      o_scs_n,
	output logic      o_sclk,
	output logic      o_sdi
);
	initial
	begin
		o_scs_n = 1'b1;
		o_sclk  = 1'b0;
		o_sdi   = 1'b0;
	end
	// Driver blocks stay off in this bench, so programming preconditions hold
	task automatic xfer(input logic [23:0] f, output logic [15:0] r);
		r = 16'h0000;
		o_scs_n = 1'b0;
		#80;
		for (int i = 23; i >= 0; i--)
		begin
			o_sdi = f[i];
			#80;
			if (i < 16)
				r[i] = i_sdo;
			o_sclk = 1'b1;
			#80;
			o_sclk = 1'b0;
		end
		#80;
		o_scs_n = 1'b1;
		// Stale data would hide a missed sample
		o_sdi = ~o_sdi;
		#40;
	endtask
endmodule

/* test_uod_top.sv */
// Self-checking bench for uod_top with a serial host model and an OTP macro stand-in.
// Assumes uod_host.sv and uod_top_sva.sv are compiled alongside.
`timescale 1ns/1ps
module test_uod_top
	import uod_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, otp_done = 1'b0, crc_bad = 1'b0;
	logic [2:0] hs_cmp = 3'h0, ls_cmp = 3'h0, hs_flt = 3'h0, ls_flt = 3'h0;
	wire        scs_n, sclk, sdi, sdo, sdo_oe, prg, ver, crc_fl;
	wire  [2:0] sw_hs, sw_ls, fl_hs, fl_ls;
	int         n_mismatch = 0, n_tests = 0;
	always #2 clk = ~clk;
	// Undriven SDO shows the inverse, so a missing drive enable corrupts reads
	uod_host host (.i_sdo(sdo_oe ? sdo : ~sdo), .o_scs_n(scs_n), .o_sclk(sclk), .o_sdi(sdi));
	uod_top dut (.I_CLK_SYS(clk), .I_RST(rst), .I_SCS_N(scs_n), .I_SCLK(sclk), .I_SDI(sdi),
		.O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_VDS_HS_CMP(hs_cmp), .I_VDS_LS_CMP(ls_cmp),
		.I_VDS_HS_FAULT(hs_flt), .I_VDS_LS_FAULT(ls_flt), .O_DIAG_SWITCH_HS(sw_hs),
		.O_DIAG_SWITCH_LS(sw_ls), .O_HS_DRAIN_SOURCE_FLAG(fl_hs),
		.O_LS_DRAIN_SOURCE_FLAG(fl_ls), .O_OTP_PROGRAM_REQ(prg), .O_OTP_VERIFY_REQ(ver),
		.I_OTP_DONE(otp_done), .I_OTP_CRC_BAD(crc_bad), .O_OTP_CRC_FAIL_FLAG(crc_fl));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] r;
		@(negedge clk);
		host.xfer({1'b0, a, d}, r);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] r;
		@(negedge clk);
		host.xfer({1'b1, a, 16'h0000}, r);
		chk(r, e);
	endtask
	task automatic pulse(input logic bad);
		@(negedge clk);
		otp_done = 1'b1;
		crc_bad  = bad;
		@(negedge clk);
		otp_done = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_regs;
		rd(ADDR_DIAG, RST_DIAG);
		rd(ADDR_SCRATCH, RST_SCRATCH);
		rd(ADDR_OTP, RST_OTP);
		wr(ADDR_SCRATCH, 16'hA5C3);
		rd(ADDR_SCRATCH, 16'hA5C3);
		chk({10'h000, sw_hs, sw_ls}, 16'h0000);
		wr(ADDR_DIAG, 16'hFFC0);
		rd(ADDR_DIAG, 16'h0000);
		wr(7'h10, 16'h1234);
		rd(7'h10, 16'h0000);
		$display("t_regs done");
	endtask
	task automatic t_diag;
		@(negedge clk) {hs_flt, ls_flt} = 6'h24;
		@(negedge clk) {hs_flt, ls_flt} = 6'h00;
		repeat (4) @(negedge clk);
		chk({10'h000, fl_hs, fl_ls}, 16'h0024);
		wr(ADDR_DIAG, 16'h0000);
		chk({10'h000, fl_hs, fl_ls}, 16'h0000);
		{hs_cmp, ls_cmp} = 6'h2A;
		wr(ADDR_DIAG, 16'h0020);
		chk({4'h0, sw_hs, sw_ls, fl_hs, fl_ls}, 16'h022A);
		wr(ADDR_DIAG, 16'h0004);
		chk({10'h000, sw_hs, sw_ls}, 16'h0002);
		chk({15'h0000, fl_ls[1]}, 16'h0001);
		@(negedge clk) ls_cmp = 3'h0;
		repeat (8) @(negedge clk);
		chk({15'h0000, fl_ls[1]}, 16'h0000);
		wr(ADDR_DIAG, 16'h0020);
		chk({13'h0000, fl_hs}, 16'h0005);
		wr(ADDR_DIAG, 16'h0000);
		chk({10'h000, fl_hs, fl_ls}, 16'h0000);
		$display("t_diag done");
	endtask
	task automatic t_unlock;
		wr(ADDR_OTP, 16'h0001);
		chk({15'h0000, prg}, 16'h0000);
		wr(ADDR_OTP, 16'h0004);
		wr(ADDR_OTP, 16'h0006);
		wr(ADDR_OTP, 16'h0002);
		wr(ADDR_OTP, 16'h0008);
		rd(ADDR_OTP, 16'h0000);
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_OTP, 16'h0004);
			wr(ADDR_OTP, 16'h0002);
			wr(ADDR_OTP, 16'h0008);
			rd(ADDR_OTP, 16'h000E);
			wr(ADDR_OTP, k ? 16'h0004 : 16'h0001);
			chk({15'h0000, prg}, k ? 16'h0000 : 16'h0001);
			rd(ADDR_OTP, 16'h0000);
			pulse(1'b0);
			chk({15'h0000, prg}, 16'h0000);
		end
		$display("t_unlock done");
	endtask
	task automatic t_verify;
		for (int k = 1; k >= 0; k--)
		begin
			wr(ADDR_OTP, 16'h0010);
			chk({14'h0000, ver, crc_fl}, 16'h0002);
			rd(ADDR_OTP, 16'h0010);
			pulse(k[0]);
			rd(ADDR_OTP, 16'h0000);
			chk({14'h0000, ver, crc_fl}, {15'h0000, k[0]});
		end
		$display("t_verify done");
	endtask
	task automatic end_of_test;
		$display("%0d comparisons, %0d mismatches", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_regs;
		t_diag;
		t_unlock;
		t_verify;
		end_of_test;
	end
	// Roughly forty frames of about 4.0 us each, with margin
	initial
	begin
		#300000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test;
	end
endmodule
